// *** hw/jse_map.svh ***
`ifndef JSE_MAP_SVH
`define JSE_MAP_SVH
// register byte offsets
`define JSE_OFF_CTRL      12'h000
`define JSE_OFF_STAT      12'h004
`define JSE_OFF_DBUS      12'h008
`define JSE_OFF_BSDATA    12'h00C
// control fields
`define JSE_CTRL_HOLD_REL 0
`define JSE_CTRL_ERASE    1
`define JSE_CTRL_PROT_PGM 2
// status fields
`define JSE_STAT_DONE     0
`define JSE_STAT_HOLD     1
`define JSE_STAT_PROT     2
`define JSE_STAT_BUSY     3
`define JSE_STAT_DENIED   4
// dbus request fields
`define JSE_DBUS_WRITE    0
`define JSE_DBUS_PAGEBUF  1
// tap instruction codes
`define JSE_IR_EXTEST     4'h0
`define JSE_IR_SAMPLE     4'h1
`define JSE_IR_IDCODE     4'hE
`define JSE_IR_BYPASS     4'hF
`define JSE_IR_LEN        4
`define JSE_BS_LEN        8
// erase phase lengths in core clocks; tms-high tck rises that put the tap in reset
`define JSE_ERASE_VOL_CYC   8'h10
`define JSE_ERASE_FLASH_CYC 8'h40
`define JSE_ERASE_PROT_CYC  8'h04
`define JSE_TMS_RESET_CNT   3'h5
`endif

// *** hw/jse_pkg.sv ***
package jse_pkg;
  // tap states, one-hot
  typedef enum logic [15:0] {
    JSE_TLR = 16'h0001, JSE_RTI = 16'h0002, JSE_SDRS = 16'h0004, JSE_CDR = 16'h0008,
    JSE_SDR = 16'h0010, JSE_E1DR = 16'h0020, JSE_PDR = 16'h0040, JSE_E2DR = 16'h0080,
    JSE_UDR = 16'h0100, JSE_SIRS = 16'h0200, JSE_CIR = 16'h0400, JSE_SIR = 16'h0800,
    JSE_E1IR = 16'h1000, JSE_PIR = 16'h2000, JSE_E2IR = 16'h4000, JSE_UIR = 16'h8000
  } jse_tap_t;
  // erase sequence, one-hot
  typedef enum logic [3:0] {
    JSE_ER_IDLE = 4'h1, JSE_ER_VOL = 4'h2, JSE_ER_FLASH = 4'h4, JSE_ER_PROT = 4'h8
  } jse_erase_t;
  // synchronised link pins
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jse_link_t;
  // state of the block apart from the tms reset counter
  typedef struct packed {
    jse_link_t  s1;
    jse_link_t  s2;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic       tck_d;
    logic       rst_s1;
    logic       rst_s2;
    logic       rst_d;
    logic       armed;
    logic       pins_on;
    jse_tap_t   tap;
    logic [3:0] ir_sh;
    logic [3:0] ir;
    logic [31:0] dr_sh;
    logic [7:0] bs_upd;
    logic       tdo;
    logic       tdo_en;
    logic       hold;
    logic       prot;
    logic       prot_pend;
    jse_erase_t er;
    logic [7:0] er_cnt;
    logic       done;
    logic       wipe_vol;
    logic       wipe_flash;
    logic       denied;
    logic       awv;
    logic [11:0] awa;
    logic       wv;
    logic [31:0] wd;
    logic       bv;
    logic       rv;
    logic [31:0] rd;
  } jse_state_t;
endpackage

// *** hw/jse_top.sv ***
`timescale 1ns/100ps
`include "jse_map.svh"
module jse_top (
  input  wire logic        CORE_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        CLK_EN_I,
  input  wire logic        EXT_RST_N_I,
  input  wire logic        TCK_I,
  input  wire logic        TMS_I,
  input  wire logic        TDI_I,
  output logic             TDO_O,
  output logic             TDO_OE_N_O,
  input  wire logic [7:0]  PIN_IN_I,
  input  wire logic [7:0]  CORE_PIN_OUT_I,
  input  wire logic [7:0]  CORE_PIN_OE_N_I,
  output logic      [7:0]  PIN_OUT_O,
  output logic      [7:0]  PIN_OE_N_O,
  output logic             CORE_HOLD_O,
  output logic             WIPE_VOL_O,
  output logic             WIPE_FLASH_O,
  input  wire logic        PROT_PGM_I,
  output logic             PROT_O,
  output logic             DBUS_REQ_O,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic [1:0]       S_AXI_BRESP,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP
);
  parameter logic [31:0] ID_CODE = 32'h0000_1001; // arbitrary identification value

  jse_pkg::jse_state_t q_ff, nxt_q;
  logic tck_rise, tck_fall, in_rst, extest, ar_ok, w_go, do_wr;
  logic [31:0] rdv;

  // refusal of a debug bus request: shared by the status flag and the request strobe
  function automatic logic dbus_refused(input logic        prot,
                                        input logic        hold,
                                        input logic [31:0] wd);
    return prot || (hold && wd[`JSE_DBUS_WRITE] && wd[`JSE_DBUS_PAGEBUF]);
  endfunction

  // pin drive: reset forces high impedance first, then extest latches, else core
  always_comb begin
    if (in_rst) begin
      PIN_OE_N_O = 8'hFF;
      PIN_OUT_O  = 8'h00;
    end else if (extest) begin
      PIN_OE_N_O = 8'h00;
      PIN_OUT_O  = q_ff.bs_upd;
    end else begin
      PIN_OE_N_O = CORE_PIN_OE_N_I;
      PIN_OUT_O  = CORE_PIN_OUT_I;
    end
  end

  assign in_rst       = !q_ff.rst_s2;
  assign extest       = (q_ff.ir == `JSE_IR_EXTEST) && q_ff.pins_on;
  assign tck_rise     = q_ff.s2.tck && !q_ff.tck_d;
  assign tck_fall     = !q_ff.s2.tck && q_ff.tck_d;
  assign TDO_O        = q_ff.tdo;
  assign TDO_OE_N_O   = !q_ff.tdo_en;
  assign CORE_HOLD_O  = q_ff.hold;
  assign WIPE_VOL_O   = q_ff.wipe_vol;
  assign WIPE_FLASH_O = q_ff.wipe_flash;
  assign PROT_O       = q_ff.prot;
  assign S_AXI_AWREADY = !q_ff.awv && !q_ff.bv;
  assign S_AXI_WREADY  = !q_ff.wv && !q_ff.bv;
  assign S_AXI_BVALID  = q_ff.bv;
  assign S_AXI_BRESP   = 2'h0;
  assign S_AXI_ARREADY = !q_ff.rv;
  assign S_AXI_RVALID  = q_ff.rv;
  assign S_AXI_RDATA   = q_ff.rd;
  assign S_AXI_RRESP   = 2'h0;
  assign ar_ok = S_AXI_ARVALID && !q_ff.rv;
  assign w_go  = q_ff.awv && q_ff.wv && !q_ff.bv;
  // debug bus request: refused while protected or page buffer write while held
  assign do_wr = w_go && (q_ff.awa == `JSE_OFF_DBUS);
  assign DBUS_REQ_O = do_wr && !dbus_refused(q_ff.prot, q_ff.hold, q_ff.wd);

  // read mux; hold release bit read back from state, erase bit reads as zero
  always_comb begin
    unique case (S_AXI_ARADDR)
      `JSE_OFF_CTRL:   rdv = {31'h0, !q_ff.hold};
      `JSE_OFF_STAT:   rdv = {27'h0, q_ff.denied, q_ff.er != jse_pkg::JSE_ER_IDLE,
                              q_ff.prot, q_ff.hold, q_ff.done};
      `JSE_OFF_BSDATA: rdv = {24'h0, q_ff.bs_upd};
      default:         rdv = 32'h0000_0000;
    endcase
  end

  // next state
  always_comb begin
    nxt_q = q_ff;
    // two-flop synchronisers for pins
    nxt_q.s1     = '{tck: TCK_I, tms: TMS_I, tdi: TDI_I};
    nxt_q.s2     = q_ff.s1;
    nxt_q.tck_d  = q_ff.s2.tck;
    nxt_q.rst_s1 = EXT_RST_N_I;
    nxt_q.rst_s2 = q_ff.rst_s1;
    nxt_q.rst_d  = q_ff.rst_s2;
    nxt_q.pin_s1 = PIN_IN_I;
    nxt_q.pin_s2 = q_ff.pin_s1;
    nxt_q.wipe_vol   = 1'b0;
    nxt_q.wipe_flash = 1'b0;
    // reset pin low: pins sleep, tap and protection reload
    if (in_rst) begin
      nxt_q.armed   = 1'b0;
      nxt_q.pins_on = 1'b0;
      nxt_q.tap     = jse_pkg::JSE_TLR;
      nxt_q.ir      = `JSE_IR_IDCODE;
      nxt_q.prot    = q_ff.prot_pend;
      nxt_q.tdo_en  = 1'b0;
    end
    // release edge: tck level decides core hold
    if (q_ff.rst_s2 && !q_ff.rst_d) begin
      nxt_q.armed = 1'b1;
      nxt_q.hold  = !q_ff.s2.tck;
    end
    if (q_ff.armed && tck_fall)
      nxt_q.pins_on = 1'b1;
    // tap on tck rising edge; a reset pin low in the same cycle wins over the edge
    if (q_ff.pins_on && tck_rise && !in_rst) begin
      unique case (q_ff.tap)
        jse_pkg::JSE_TLR:  nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_TLR  : jse_pkg::JSE_RTI;
        jse_pkg::JSE_RTI:  nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_SDRS : jse_pkg::JSE_RTI;
        jse_pkg::JSE_SDRS: nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_SIRS : jse_pkg::JSE_CDR;
        jse_pkg::JSE_CDR:  nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_E1DR : jse_pkg::JSE_SDR;
        jse_pkg::JSE_SDR:  nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_E1DR : jse_pkg::JSE_SDR;
        jse_pkg::JSE_E1DR: nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_UDR  : jse_pkg::JSE_PDR;
        jse_pkg::JSE_PDR:  nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_E2DR : jse_pkg::JSE_PDR;
        jse_pkg::JSE_E2DR: nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_UDR  : jse_pkg::JSE_SDR;
        jse_pkg::JSE_UDR:  nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_SDRS : jse_pkg::JSE_RTI;
        jse_pkg::JSE_SIRS: nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_TLR  : jse_pkg::JSE_CIR;
        jse_pkg::JSE_CIR:  nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_E1IR : jse_pkg::JSE_SIR;
        jse_pkg::JSE_SIR:  nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_E1IR : jse_pkg::JSE_SIR;
        jse_pkg::JSE_E1IR: nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_UIR  : jse_pkg::JSE_PIR;
        jse_pkg::JSE_PIR:  nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_E2IR : jse_pkg::JSE_PIR;
        jse_pkg::JSE_E2IR: nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_UIR  : jse_pkg::JSE_SIR;
        jse_pkg::JSE_UIR:  nxt_q.tap = q_ff.s2.tms ? jse_pkg::JSE_SDRS : jse_pkg::JSE_RTI;
        default:           nxt_q.tap = jse_pkg::JSE_TLR;
      endcase
      // register actions; exit and pause states fall through untouched
      unique case (q_ff.tap)
        jse_pkg::JSE_TLR: nxt_q.ir = `JSE_IR_IDCODE;
        jse_pkg::JSE_CIR: nxt_q.ir_sh = 4'h1;
        jse_pkg::JSE_SIR: nxt_q.ir_sh = {q_ff.s2.tdi, q_ff.ir_sh[3:1]};
        jse_pkg::JSE_UIR: nxt_q.ir = q_ff.ir_sh;
        jse_pkg::JSE_CDR: begin
          unique case (q_ff.ir)
            `JSE_IR_IDCODE: nxt_q.dr_sh = ID_CODE;
            `JSE_IR_EXTEST,
            `JSE_IR_SAMPLE: nxt_q.dr_sh = {24'h0, q_ff.pin_s2};
            default:        nxt_q.dr_sh = 32'h0;
          endcase
        end
        jse_pkg::JSE_SDR: begin
          unique case (q_ff.ir)
            `JSE_IR_IDCODE: nxt_q.dr_sh = {q_ff.s2.tdi, q_ff.dr_sh[31:1]};
            `JSE_IR_EXTEST,
            `JSE_IR_SAMPLE: nxt_q.dr_sh = {24'h0, q_ff.s2.tdi, q_ff.dr_sh[7:1]};
            default:        nxt_q.dr_sh = {31'h0, q_ff.s2.tdi};
          endcase
        end
        jse_pkg::JSE_UDR:
          if (q_ff.ir == `JSE_IR_EXTEST || q_ff.ir == `JSE_IR_SAMPLE)
            nxt_q.bs_upd = q_ff.dr_sh[7:0];
        default: ;
      endcase
    end
    // tdo on tck falling edge, only in shift states
    if (q_ff.pins_on && tck_fall && !in_rst) begin
      nxt_q.tdo_en = (q_ff.tap == jse_pkg::JSE_SIR) || (q_ff.tap == jse_pkg::JSE_SDR);
      nxt_q.tdo    = (q_ff.tap == jse_pkg::JSE_SIR) ? q_ff.ir_sh[0] : q_ff.dr_sh[0];
    end
    // axi write channel capture
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      nxt_q.awv = 1'b1;
      nxt_q.awa = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      nxt_q.wv = 1'b1;
      nxt_q.wd = S_AXI_WDATA;
    end
    if (w_go) begin
      nxt_q.awv = 1'b0;
      nxt_q.wv  = 1'b0;
      nxt_q.bv  = 1'b1;
      if (q_ff.awa == `JSE_OFF_CTRL) begin
        if (q_ff.wd[`JSE_CTRL_HOLD_REL] && !q_ff.prot && !(q_ff.rst_s2 && !q_ff.rst_d))
          nxt_q.hold = 1'b0;
        if (q_ff.wd[`JSE_CTRL_ERASE] && q_ff.er == jse_pkg::JSE_ER_IDLE) begin
          nxt_q.er     = jse_pkg::JSE_ER_VOL;
          nxt_q.er_cnt = `JSE_ERASE_VOL_CYC;
          nxt_q.done   = 1'b0;
        end
      end
    end
    if (do_wr)
      nxt_q.denied = dbus_refused(q_ff.prot, q_ff.hold, q_ff.wd);
    if (PROT_PGM_I)
      nxt_q.prot_pend = 1'b1;
    if (q_ff.bv && S_AXI_BREADY)
      nxt_q.bv = 1'b0;
    // axi read
    if (ar_ok) begin
      nxt_q.rv = 1'b1;
      nxt_q.rd = rdv;
    end else if (q_ff.rv && S_AXI_RREADY)
      nxt_q.rv = 1'b0;
    // erase sequence: volatile, flash, protection
    if (q_ff.er != jse_pkg::JSE_ER_IDLE) begin
      nxt_q.er_cnt = q_ff.er_cnt - 8'h01;
      nxt_q.wipe_vol   = (q_ff.er == jse_pkg::JSE_ER_VOL);
      nxt_q.wipe_flash = (q_ff.er == jse_pkg::JSE_ER_FLASH); // user page never touched
      if (q_ff.er_cnt == 8'h01) begin
        unique case (q_ff.er)
          jse_pkg::JSE_ER_VOL: begin
            nxt_q.er     = jse_pkg::JSE_ER_FLASH;
            nxt_q.er_cnt = `JSE_ERASE_FLASH_CYC;
          end
          jse_pkg::JSE_ER_FLASH: begin
            nxt_q.er     = jse_pkg::JSE_ER_PROT;
            nxt_q.er_cnt = `JSE_ERASE_PROT_CYC;
          end
          default: begin
            nxt_q.er        = jse_pkg::JSE_ER_IDLE;
            nxt_q.prot      = 1'b0;
            // a program landing in the same cycle still wins over the wipe
            nxt_q.prot_pend = PROT_PGM_I;
            nxt_q.done = 1'b1;
          end
        endcase
      end
    end
  end

  // one register for all block state but the tms counter; clock enable freezes both
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      q_ff     <= '0;
      q_ff.tap <= jse_pkg::JSE_TLR;
      q_ff.ir  <= `JSE_IR_IDCODE;
      q_ff.er  <= jse_pkg::JSE_ER_IDLE;
      q_ff.hold <= 1'b1;
    end else if (CLK_EN_I) begin
      q_ff <= nxt_q;
    end
  end

  // five tms-high tck rises counted for reaching reset from anywhere
  logic [2:0] tms_cnt_ff;
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I)
      tms_cnt_ff <= 3'h0;
    else if (CLK_EN_I && tck_rise && q_ff.pins_on)
      tms_cnt_ff <= !q_ff.s2.tms ? 3'h0 :
                    (tms_cnt_ff == `JSE_TMS_RESET_CNT) ? tms_cnt_ff : tms_cnt_ff + 3'h1;
  end

  chk_tms_reset: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    (tms_cnt_ff == `JSE_TMS_RESET_CNT) && CLK_EN_I |-> q_ff.tap == jse_pkg::JSE_TLR)
    else $error("tap not in reset after five tms highs");
  // guards: the reset pin seen by the first flop must float the pins one cycle later
  chk_pin_hiz: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    CLK_EN_I && !q_ff.rst_s1 |=> PIN_OE_N_O == 8'hFF) else $error("pins driven during reset");
  chk_ir_update: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    CLK_EN_I && q_ff.pins_on && tck_rise && q_ff.tap == jse_pkg::JSE_UIR && q_ff.rst_s2
    |=> q_ff.ir == $past(q_ff.ir_sh)) else $error("ir not updated");
  chk_ir_stable: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    CLK_EN_I && q_ff.rst_s2 && q_ff.tap != jse_pkg::JSE_UIR && q_ff.tap != jse_pkg::JSE_TLR
    |=> $stable(q_ff.ir)) else $error("ir changed outside update");
  chk_bs_stable: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    q_ff.tap != jse_pkg::JSE_UDR |=> $stable(q_ff.bs_upd)) else $error("latch moved");
  chk_tdo_quiet: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    q_ff.tdo_en |-> !q_ff.rst_d || !q_ff.rst_s2 ||
    q_ff.tap inside {jse_pkg::JSE_SIR, jse_pkg::JSE_SDR, jse_pkg::JSE_E1IR,
    jse_pkg::JSE_E1DR}) else $error("tdo driven outside shift");
  chk_hold_strap: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    CLK_EN_I && q_ff.rst_s2 && !q_ff.rst_d |=> q_ff.hold == !$past(q_ff.s2.tck))
    else $error("hold strap wrong");
  chk_erase_done: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    $rose(q_ff.done) |-> !q_ff.prot && $past(q_ff.er) == jse_pkg::JSE_ER_PROT)
    else $error("done without erase");
  chk_prot_deny: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    CLK_EN_I && do_wr && q_ff.prot |=> q_ff.denied) else $error("protected access allowed");
  chk_dbus_gate: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    do_wr && q_ff.hold && q_ff.wd[`JSE_DBUS_WRITE] && q_ff.wd[`JSE_DBUS_PAGEBUF]
    |-> !DBUS_REQ_O) else $error("page buffer write passed while held");
  chk_wipe_order: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    CLK_EN_I && $fell(q_ff.wipe_vol) |-> q_ff.wipe_flash && !q_ff.done)
    else $error("flash wipe did not follow volatile wipe");
  chk_pins_asleep: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    !q_ff.pins_on |-> q_ff.tap == jse_pkg::JSE_TLR) else $error("tap moved while pins asleep");
  chk_tdo_shift: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    CLK_EN_I && q_ff.pins_on && tck_fall && !in_rst && q_ff.tap == jse_pkg::JSE_SDR
    |=> TDO_O == $past(q_ff.dr_sh[0])) else $error("tdo not the next data bit");
  chk_idcode_tlr: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    CLK_EN_I && q_ff.pins_on && tck_rise && !in_rst && q_ff.tap == jse_pkg::JSE_TLR
    |=> q_ff.ir == `JSE_IR_IDCODE) else $error("idcode not default after tap reset");

  // main scenarios that the bench is expected to reach
  cov_ir_scan: cover property (@(posedge CORE_CLK_I) q_ff.tap == jse_pkg::JSE_UIR);
  cov_extest: cover property (@(posedge CORE_CLK_I) extest && !in_rst);
  cov_erase: cover property (@(posedge CORE_CLK_I) $rose(q_ff.done));
  cov_dr_bypass: cover property (@(posedge CORE_CLK_I)
    q_ff.tap == jse_pkg::JSE_UDR && q_ff.ir == `JSE_IR_BYPASS);
endmodule // jse_top

// *** verif/jse_jtag_model.sv ***
`timescale 1ns/100ps
// debugger model on the far side of the link; tck is stepped on the core clock grid
module jse_jtag_model (
  input  wire logic clk_i,
  input  wire logic tdo_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  localparam int HALF = 6; // 24 ns per level, a 48 ns link period

  // tck starts low so that a reset release asks for a held core
  initial begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h0;
  end

  // one link period: new tms/tdi with the fall, tdo read just before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge clk_i);
    tck_o <= 1'h0;
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (HALF) @(posedge clk_i);
    tdo = tdo_i;
    tck_o <= 1'h1;
    repeat (HALF - 1) @(posedge clk_i);
  endtask

  // tck stands still between frames at the level the scenario needs
  task automatic park(input logic lvl);
    @(posedge clk_i);
    tck_o <= lvl;
  endtask

  // five periods with tms high, then one low, lands in run-test/idle
  task automatic reset_tap();
    logic t;
    repeat (5) step(1'h1, 1'h0, t);
    step(1'h0, 1'h0, t);
  endtask

  // instruction scan; without idle it stops in update-ir so a data scan may follow
  task automatic scan_ir(input logic [3:0] ir, input logic idle);
    logic t;
    for (int i = 0; i < 4; i++) step(i < 2, 1'h0, t);
    for (int i = 0; i < 4; i++) step(i == 3, ir[i], t);
    step(1'h1, 1'h0, t);
    if (idle) step(1'h0, 1'h0, t);
  endtask

  // data scan of n bits, lsb first, ending back in run-test/idle
  task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic t;
    dout = 32'h0;
    for (int i = 0; i < 3; i++) step(i == 0, 1'h0, t);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    step(1'h1, 1'h0, t);
    step(1'h0, 1'h0, t);
  endtask
endmodule // jse_jtag_model

// *** verif/jse_top_tb_top.sv ***
`timescale 1ns/100ps
`include "jse_map.svh"
// bench: axi-lite master tasks plus a debugger model on the link
module jse_top_tb_top;
  localparam logic [31:0] ID_VAL = 32'h1234_5671; // arbitrary identification value
  logic        clk, nrst_n, ext_rst_n, prot_pgm, tck, tms, tdi, tdo, tdo_oe_n;
  logic [7:0]  pin_in, core_out, core_oe_n, pin_out, pin_oe_n;
  logic        hold, wvol, wfl, prot, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, dout;
  logic [1:0]  bresp, rresp;
  logic        bad, dbus_req;
  int          err_total, comparisons, v, f;
  int          grants = 0;

  // 250 MHz core clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  jse_top #(.ID_CODE(ID_VAL)) u_jse_top (
    .CORE_CLK_I(clk), .NRST_I(nrst_n), .CLK_EN_I(1'h1), .EXT_RST_N_I(ext_rst_n),
    .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .TDO_O(tdo), .TDO_OE_N_O(tdo_oe_n),
    .PIN_IN_I(pin_in), .CORE_PIN_OUT_I(core_out), .CORE_PIN_OE_N_I(core_oe_n),
    .PIN_OUT_O(pin_out), .PIN_OE_N_O(pin_oe_n), .CORE_HOLD_O(hold), .WIPE_VOL_O(wvol),
    .WIPE_FLASH_O(wfl), .PROT_PGM_I(prot_pgm), .PROT_O(prot), .DBUS_REQ_O(dbus_req),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp)
  );

  // a released tdo floats to its pull-up, so an undriven shift reads ones
  jse_jtag_model u_jse_jtag_model (
    .clk_i(clk), .tdo_i(tdo_oe_n ? 1'h1 : tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi)
  );

  // granted debug bus requests, counted as the strobe is seen
  always @(posedge clk) begin
    if (dbus_req === 1'h1) grants <= grants + 1;
  end

  // one comparison, counted; a mismatch is reported at once
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // the single place where the run ends
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // a bus wait that ran out is a mismatch and ends the run
  task automatic expire();
    err_total++;
    $display("unexpected at %0t: bus wait ran out, seen %h expected %h", $time, 1'h0, 1'h1);
    print_verdict();
  endtask

  // write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int  n;
    logic aw_on;
    logic w_on;
    n = 0;
    aw_on = 1'h1;
    w_on = 1'h1;
    @(posedge clk);
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= d;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (n > 400) expire();
      if (aw_on && awready) begin
        aw_on = 1'h0;
        awvalid <= 1'h0;
      end
      if (w_on && wready) begin
        w_on = 1'h0;
        wvalid <= 1'h0;
      end
    end while (bvalid !== 1'h1);
    check(32'(bresp), 32'h0);
    bready <= 1'h0;
  endtask

  // read: rready held until rvalid is seen, data taken at that edge
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (n > 400) expire();
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    check(32'(rresp), 32'h0);
    rready <= 1'h0;
  endtask

  // one status bit against its expected level
  task automatic stat_is(input int b, input logic e);
    axi_rd(`JSE_OFF_STAT, rd);
    check(32'(rd[b]), 32'(e));
  endtask

  // external reset pulse; tck stays wherever the model parked it
  task automatic ext_cycle();
    @(posedge clk);
    ext_rst_n <= 1'h0;
    repeat (4) @(posedge clk);
    check(32'(pin_oe_n), 32'hFF);
    ext_rst_n <= 1'h1;
    repeat (8) @(posedge clk);
  endtask

  // main sequence
  initial begin
    {nrst_n, ext_rst_n, prot_pgm, awvalid, wvalid, bready, arvalid, rready} = 8'h0;
    {awaddr, araddr, wdata} = 56'h0;
    pin_in = 8'h3C;
    core_out = 8'h55;
    core_oe_n = 8'h0F;
    err_total = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    nrst_n <= 1'h1;
    // tck low across the release holds the core; page-buffer writes then refused
    ext_cycle();
    check(32'(hold), 32'h1);
    check(32'(pin_oe_n), 32'h0F);
    axi_wr(`JSE_OFF_DBUS, 32'h1);
    check(32'(grants), 32'h1);
    stat_is(`JSE_STAT_DENIED, 1'h0);
    axi_wr(`JSE_OFF_DBUS, 32'h3);
    stat_is(`JSE_STAT_DENIED, 1'h1);
    check(32'(grants), 32'h1);
    stat_is(`JSE_STAT_HOLD, 1'h1);
    axi_wr(`JSE_OFF_CTRL, 32'h1);
    check(32'(hold), 32'h0);
    axi_rd(12'h010, rd);
    check(rd, 32'h0);
    $display("test core hold finished");
    // link wakes on a tck fall; idcode first, then bypass, preload and extest
    u_jse_jtag_model.park(1'h1);
    u_jse_jtag_model.reset_tap();
    check(32'(tdo_oe_n), 32'h1);
    u_jse_jtag_model.scan_dr(32, 32'h0, dout);
    check(dout, ID_VAL);
    u_jse_jtag_model.scan_ir(`JSE_IR_BYPASS, 1'h0);
    u_jse_jtag_model.scan_dr(8, 32'hA5, dout);
    check(dout, 32'h4A);
    u_jse_jtag_model.scan_ir(`JSE_IR_SAMPLE, 1'h1);
    u_jse_jtag_model.scan_dr(8, 32'h81, dout);
    check(dout, 32'h3C);
    check(32'(pin_out), 32'h55);
    axi_rd(`JSE_OFF_BSDATA, rd);
    check(rd, 32'h81);
    u_jse_jtag_model.scan_ir(`JSE_IR_EXTEST, 1'h1);
    check(32'(pin_out), 32'h81);
    check(32'(pin_oe_n), 32'h0);
    u_jse_jtag_model.scan_ir(`JSE_IR_IDCODE, 1'h1);
    check(32'(pin_out), 32'h55);
    $display("test scan chain finished");
    // protection is pending until a reset; tck is high so the core runs
    nrst_n <= 1'h0;
    repeat (2) @(posedge clk);
    nrst_n <= 1'h1;
    repeat (4) @(posedge clk); // reset pin synchroniser drains before programming
    prot_pgm <= 1'h1;
    @(posedge clk);
    prot_pgm <= 1'h0;
    repeat (4) @(posedge clk);
    check(32'(prot), 32'h0);
    ext_cycle();
    check(32'(prot), 32'h1);
    check(32'(hold), 32'h0);
    axi_wr(`JSE_OFF_DBUS, 32'h1);
    stat_is(`JSE_STAT_DENIED, 1'h1);
    check(32'(grants), 32'h1);
    $display("test protection finished");
    // erase: volatile, then flash, then protection, then the completion flag
    v = 0;
    f = 0;
    bad = 1'h0;
    fork
      axi_wr(`JSE_OFF_CTRL, 32'h2);
      repeat (150) begin
        @(posedge clk);
        if (wfl === 1'h1 && v != int'(`JSE_ERASE_VOL_CYC)) bad = 1'h1;
        if (prot !== 1'h1 && f != int'(`JSE_ERASE_FLASH_CYC)) bad = 1'h1;
        if (wvol === 1'h1) v++;
        if (wfl === 1'h1) f++;
      end
    join
    check(32'(v), 32'(`JSE_ERASE_VOL_CYC));
    check(32'(f), 32'(`JSE_ERASE_FLASH_CYC));
    check(32'(bad), 32'h0);
    check(32'(prot), 32'h0);
    rd = 32'h0;
    for (int k = 0; k < 20 && rd[`JSE_STAT_DONE] !== 1'h1; k++) axi_rd(`JSE_OFF_STAT, rd);
    check(32'(rd[`JSE_STAT_DONE]), 32'h1);
    check(32'(rd[`JSE_STAT_BUSY]), 32'h0);
    $display("test chip erase finished");
    print_verdict();
  end
endmodule // jse_top_tb_top
